/* usfb_pkg.sv */
// What this block does
// RULE_01 - Mode field picks async, sync, reserved, SPI; here the SPI code runs asynchronous framing.
// RULE_02 - Parity field picks off, reserved, even, odd.
// RULE_03 - Transmitter appends computed parity to each frame.
// RULE_04 - Receiver checks parity and flags mismatches.
// RULE_05 - Stop select gives one or two stop bits.
// RULE_06 - Receiver ignores the stop-bit select.
// RULE_07 - Size from high bit plus two low bits.
// RULE_08 - Sync polarity chooses change and sample edges.
// RULE_09 - Software keeps polarity zero in async mode.
// RULE_10 - Divisor is twelve bits across two bytes.
// RULE_11 - Software writes zeros to divisor bits 15:12.
// RULE_12 - Low byte write reloads the prescaler immediately.
// RULE_13 - Software changes divisor only between frames.
// RULE_14 - Software keeps baud rate error small.
// RULE_15 - Double speed halves fixed divisor in async.
// RULE_16 - Bit rate is clock over N times divisor+1.
package usfb_pkg;
  localparam logic [7:0] USFB_OFS_FRAME = 8'h00;
  localparam logic [7:0] USFB_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] USFB_OFS_BAUD_LO = 8'h08;
  localparam logic [7:0] USFB_OFS_BAUD_HI = 8'h0C;
  localparam logic [7:0] USFB_OFS_STATUS = 8'h10;
  localparam logic [7:0] USFB_OFS_TXDATA = 8'h14;
  localparam logic [7:0] USFB_OFS_RXDATA = 8'h18;
  localparam int USFB_POS_MODE = 6;
  localparam int USFB_POS_PARITY = 4;
  localparam int USFB_POS_STOP = 3;
  localparam int USFB_POS_SIZE = 1;
  localparam int USFB_POS_POL = 0;
  localparam int USFB_POS_SIZE_HI = 2;
  localparam int USFB_POS_RXEN = 4;
  localparam int USFB_POS_TXEN = 3;
  localparam int USFB_POS_DBL = 1;
  localparam logic [7:0] USFB_RST_FRAME = 8'h06;
  localparam logic [7:0] USFB_RST_CTRL2 = 8'h00;
  localparam logic [11:0] USFB_RST_BAUD = 12'h000;
  localparam logic [1:0] USFB_MODE_ASYNC = 2'h0;
  localparam logic [1:0] USFB_MODE_SYNC = 2'h1;
  localparam logic [1:0] USFB_PAR_EVEN = 2'h2;
  localparam logic [1:0] USFB_PAR_ODD = 2'h3;
  localparam int USFB_OVS_NORMAL = 16;
  localparam int USFB_OVS_DOUBLE = 8;
  localparam logic [1:0] USFB_RESP_OKAY = 2'h0;
  localparam logic [1:0] USFB_RESP_SLVERR = 2'h2;

  // Number of data bits; reserved size codes fall back to eight.
  function automatic logic [3:0] usfb_char_bits(input logic [2:0] code);
    case (code)
      3'h0: usfb_char_bits = 4'h5;
      3'h1: usfb_char_bits = 4'h6;
      3'h2: usfb_char_bits = 4'h7;
      3'h7: usfb_char_bits = 4'h9;
      default: usfb_char_bits = 4'h8;
    endcase
  endfunction

  // Parity over the used data bits, odd mode inverted.
  function automatic logic usfb_parity(input logic [8:0] data, input logic [3:0] nbits,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) begin
        p = p ^ data[i];
      end
    end
    usfb_parity = p;
  endfunction
endpackage

/* usfb_baud_gen.sv */
`timescale 1ns/10ps
module usfb_baud_gen import usfb_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic reload,
  output logic tick
);
  if (DIV_W < 1 || DIV_W > 16) begin
    $error("usfb_baud_gen: DIV_W out of range");
  end
  logic [DIV_W-1:0] count_ff;

  // Counting down from the divisor gives one tick every divisor+1 clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else if (reload) begin
      count_ff <= divisor; // RULE_12
    end else if (count_ff == '0) begin
      count_ff <= divisor; // RULE_16
    end else begin
      count_ff <= count_ff - 1'b1;
    end
  end
  assign tick = (count_ff == '0) && !reload;
endmodule

/* usfb_sync2.sv */
`timescale 1ns/10ps
module usfb_sync2 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 1'b1;
      q_ff <= 1'b1;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule

/* usfb_top.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module usfb_top import usfb_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic transmit_pin,
  input wire logic receive_pin,
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe
);
  typedef enum logic [2:0] {USFB_TX_IDLE, USFB_TX_START, USFB_TX_DATA, USFB_TX_PAR,
                            USFB_TX_STOP} usfb_tx_state_t;
  typedef enum logic [2:0] {USFB_RX_IDLE, USFB_RX_START, USFB_RX_DATA, USFB_RX_PAR,
                            USFB_RX_STOP} usfb_rx_state_t;

  logic [7:0] frame_format_control_ff;
  logic [7:0] ctrl2_ff;
  logic [11:0] baud_divisor_ff;
  logic aw_held_ff, w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [8:0] tx_buf_ff;
  logic tx_full_ff;
  logic [8:0] rx_buf_ff;
  logic rx_done_ff, parity_error_flag_ff, frame_err_ff;
  usfb_tx_state_t tx_state_ff;
  usfb_rx_state_t rx_state_ff;
  logic [8:0] tx_sh_ff, rx_sh_ff;
  logic [3:0] tx_bit_ff, rx_bit_ff, tx_os_ff, rx_os_ff;
  logic tx_stop2_ff, tx_par_ff, rx_par_ff;
  logic transmit_pin_ff;
  logic xck_gen_ff, xck_prev_ff;

  logic [1:0] operating_mode_select;
  logic [1:0] parity_mode_field;
  logic stop_bit_select, sync_clock_polarity, double_speed_bit, sync_mode;
  logic [2:0] char_size;
  logic [3:0] nbits;
  logic par_en, par_odd;
  logic baud_tick, baud_reload, rx_s, xck_s, xck_cur, change_edge, sample_edge;
  logic tx_step, rx_step;
  logic [3:0] os_last;
  logic wr_fire, rd_fire;

  assign operating_mode_select = frame_format_control_ff[USFB_POS_MODE +: 2]; // RULE_01
  assign parity_mode_field = frame_format_control_ff[USFB_POS_PARITY +: 2];
  assign stop_bit_select = frame_format_control_ff[USFB_POS_STOP];
  assign sync_clock_polarity = frame_format_control_ff[USFB_POS_POL];
  assign char_size = {ctrl2_ff[USFB_POS_SIZE_HI],
                      frame_format_control_ff[USFB_POS_SIZE +: 2]}; // RULE_07
  assign nbits = usfb_char_bits(char_size); // RULE_07
  assign par_en = parity_mode_field[1]; // RULE_02
  assign par_odd = parity_mode_field == USFB_PAR_ODD; // RULE_02
  assign double_speed_bit = ctrl2_ff[USFB_POS_DBL];
  assign sync_mode = operating_mode_select == USFB_MODE_SYNC; // RULE_01
  // Reserved and SPI modes fall back to asynchronous framing.
  assign os_last = (double_speed_bit && !sync_mode) ?
                   4'(USFB_OVS_DOUBLE - 1) : 4'(USFB_OVS_NORMAL - 1); // RULE_15

  // AXI4-Lite write: address and data are taken in either order.
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire = s_axi_arvalid && !rvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= USFB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        case ({awaddr_ff[7:2], 2'b00})
          USFB_OFS_FRAME, USFB_OFS_CTRL2, USFB_OFS_BAUD_LO, USFB_OFS_BAUD_HI,
          USFB_OFS_STATUS, USFB_OFS_TXDATA, USFB_OFS_RXDATA: bresp_ff <= USFB_RESP_OKAY;
          default: bresp_ff <= USFB_RESP_SLVERR;
        endcase
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  logic wr_lane0;
  logic [7:0] wr_reg;
  assign wr_lane0 = wr_fire && wstrb_ff[0];
  assign wr_reg = {awaddr_ff[7:2], 2'b00};
  assign baud_reload = wr_lane0 && wr_reg == USFB_OFS_BAUD_LO; // RULE_12
  // The register updates on the same edge, so the reload takes the new byte directly.
  logic [11:0] baud_next;
  assign baud_next = baud_reload ? {baud_divisor_ff[11:8], wdata_ff[7:0]} : baud_divisor_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_format_control_ff <= USFB_RST_FRAME;
      ctrl2_ff <= USFB_RST_CTRL2;
      baud_divisor_ff <= USFB_RST_BAUD;
    end else if (wr_lane0) begin
      if (wr_reg == USFB_OFS_FRAME) begin
        frame_format_control_ff <= wdata_ff[7:0];
      end
      if (wr_reg == USFB_OFS_CTRL2) begin
        ctrl2_ff <= wdata_ff[7:0];
      end
      if (wr_reg == USFB_OFS_BAUD_LO) begin
        baud_divisor_ff[7:0] <= wdata_ff[7:0]; // RULE_10
      end
      if (wr_reg == USFB_OFS_BAUD_HI) begin
        // Bits 15:12 are not stored, so they always read as zero.
        baud_divisor_ff[11:8] <= wdata_ff[3:0]; // RULE_10
      end
    end
  end

  // Read side; reading received data clears the receive flags.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= USFB_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= USFB_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        USFB_OFS_FRAME: rdata_ff <= {24'h0, frame_format_control_ff};
        USFB_OFS_CTRL2: rdata_ff <= {24'h0, ctrl2_ff};
        USFB_OFS_BAUD_LO: rdata_ff <= {24'h0, baud_divisor_ff[7:0]};
        USFB_OFS_BAUD_HI: rdata_ff <= {28'h0, baud_divisor_ff[11:8]};
        USFB_OFS_STATUS: rdata_ff <= {27'h0, !tx_full_ff, frame_err_ff,
                                      parity_error_flag_ff, rx_done_ff, tx_state_ff != USFB_TX_IDLE};
        USFB_OFS_TXDATA: rdata_ff <= {23'h0, tx_buf_ff};
        USFB_OFS_RXDATA: rdata_ff <= {23'h0, rx_buf_ff};
        default: begin
          rdata_ff <= 32'h0;
          rresp_ff <= USFB_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  usfb_baud_gen #(.DIV_W(12)) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .divisor(baud_next),
    .reload(baud_reload),
    .tick(baud_tick)
  );
  usfb_sync2 u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(receive_pin),
    .q(rx_s)
  );
  usfb_sync2 u_xck_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sync_clock_pin_i),
    .q(xck_s)
  );

  // The device is clock slave in synchronous mode and master in async mode.
  assign xck_cur = sync_mode ? xck_s : xck_gen_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xck_gen_ff <= 1'b0;
      xck_prev_ff <= 1'b0;
    end else begin
      if (baud_tick) begin
        xck_gen_ff <= !xck_gen_ff;
      end
      xck_prev_ff <= xck_cur;
    end
  end
  assign change_edge = sync_mode && (xck_cur != xck_prev_ff) &&
                       (xck_cur == !sync_clock_polarity); // RULE_08
  assign sample_edge = sync_mode && (xck_cur != xck_prev_ff) &&
                       (xck_cur == sync_clock_polarity); // RULE_08
  assign sync_clock_pin_o = xck_gen_ff;
  assign sync_clock_pin_oe = !sync_mode;

  // Transmitter.
  assign tx_step = sync_mode ? change_edge : (baud_tick && tx_os_ff == os_last);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_ff <= USFB_TX_IDLE;
      tx_sh_ff <= 9'h0;
      tx_bit_ff <= 4'h0;
      tx_os_ff <= 4'h0;
      tx_stop2_ff <= 1'b0;
      tx_par_ff <= 1'b0;
      transmit_pin_ff <= 1'b1;
      tx_buf_ff <= 9'h0;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_fire && wr_reg == USFB_OFS_TXDATA && !tx_full_ff) begin
        tx_buf_ff <= wdata_ff[8:0];
        tx_full_ff <= 1'b1;
      end
      if (baud_tick) begin
        tx_os_ff <= (tx_os_ff >= os_last) ? 4'h0 : tx_os_ff + 4'h1;
      end
      // Starting as the last stop bit ends keeps back-to-back frames at the chosen stop count.
      if ((tx_state_ff == USFB_TX_IDLE || (tx_state_ff == USFB_TX_STOP && !tx_stop2_ff)) &&
          tx_full_ff && ctrl2_ff[USFB_POS_TXEN] && tx_step) begin // RULE_05
        tx_sh_ff <= tx_buf_ff;
        tx_par_ff <= usfb_parity(tx_buf_ff, nbits, par_odd); // RULE_03
        tx_full_ff <= 1'b0;
        tx_state_ff <= USFB_TX_START;
        transmit_pin_ff <= 1'b0;
      end else if (tx_step) begin
        case (tx_state_ff)
          USFB_TX_START, USFB_TX_DATA: begin
            if (tx_state_ff == USFB_TX_DATA && tx_bit_ff == nbits) begin
              tx_bit_ff <= 4'h0;
              tx_stop2_ff <= stop_bit_select; // RULE_05
              transmit_pin_ff <= par_en ? tx_par_ff : 1'b1; // RULE_03
              tx_state_ff <= par_en ? USFB_TX_PAR : USFB_TX_STOP;
            end else begin
              transmit_pin_ff <= tx_sh_ff[0];
              tx_sh_ff <= tx_sh_ff >> 1;
              tx_bit_ff <= tx_bit_ff + 4'h1;
              tx_state_ff <= USFB_TX_DATA;
            end
          end
          USFB_TX_PAR: begin
            transmit_pin_ff <= 1'b1;
            tx_state_ff <= USFB_TX_STOP;
          end
          USFB_TX_STOP: begin
            transmit_pin_ff <= 1'b1;
            tx_stop2_ff <= 1'b0;
            tx_state_ff <= tx_stop2_ff ? USFB_TX_STOP : USFB_TX_IDLE; // RULE_05
          end
          default: tx_state_ff <= USFB_TX_IDLE;
        endcase
      end
    end
  end
  assign transmit_pin = transmit_pin_ff;

  // Receiver: one stop bit always checked, whatever the stop select says.
  assign rx_step = sync_mode ? sample_edge : (baud_tick && rx_os_ff == os_last);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_ff <= USFB_RX_IDLE;
      rx_sh_ff <= 9'h0;
      rx_bit_ff <= 4'h0;
      rx_os_ff <= 4'h0;
      rx_par_ff <= 1'b0;
      rx_buf_ff <= 9'h0;
      rx_done_ff <= 1'b0;
      parity_error_flag_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end else begin
      if (rd_fire && {s_axi_araddr[7:2], 2'b00} == USFB_OFS_RXDATA) begin
        rx_done_ff <= 1'b0;
        parity_error_flag_ff <= 1'b0;
        frame_err_ff <= 1'b0;
      end
      if (baud_tick) begin
        rx_os_ff <= (rx_os_ff >= os_last) ? 4'h0 : rx_os_ff + 4'h1;
      end
      if (rx_state_ff == USFB_RX_IDLE) begin
        if (!rx_s && ctrl2_ff[USFB_POS_RXEN]) begin
          // Aligning the phase on the start edge puts samples mid-bit.
          rx_os_ff <= 4'((int'(os_last) + 1) / 2);
          // In synchronous mode the start state absorbs the start bit's own sample edge.
          rx_state_ff <= USFB_RX_START;
          rx_bit_ff <= 4'h0;
          rx_sh_ff <= 9'h0;
        end
      end else if (rx_step) begin
        case (rx_state_ff)
          USFB_RX_START: rx_state_ff <= USFB_RX_DATA;
          USFB_RX_DATA: begin
            rx_sh_ff[rx_bit_ff] <= rx_s;
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff + 4'h1 == nbits) begin
              rx_state_ff <= par_en ? USFB_RX_PAR : USFB_RX_STOP;
            end
          end
          USFB_RX_PAR: begin
            rx_par_ff <= rx_s;
            rx_state_ff <= USFB_RX_STOP;
          end
          USFB_RX_STOP: begin
            rx_buf_ff <= rx_sh_ff;
            rx_done_ff <= 1'b1; // RULE_06
            frame_err_ff <= !rx_s;
            parity_error_flag_ff <= par_en &&
                                    (usfb_parity(rx_sh_ff, nbits, par_odd) != rx_par_ff); // RULE_04
            rx_state_ff <= USFB_RX_IDLE;
          end
          default: rx_state_ff <= USFB_RX_IDLE;
        endcase
      end
    end
  end
endmodule

/* usfb_sva.sv */
`timescale 1ns/10ps
module usfb_sva import usfb_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic transmit_pin,
  input wire logic sync_clock_pin_o,
  input wire logic sync_clock_pin_oe
);
  logic [7:0] wa, ra, fr;
  logic [31:0] wd;
  logic [11:0] dv;
  logic db, wok, rok;
  logic [15:0] lo_n;
  logic [16:0] bt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign bt = (db ? 17'h8 : 17'h10) * ({5'h0, dv} + 17'h1);
  assign wok = wa <= 8'h18 && wa[1:0] == 2'h0;
  assign rok = ra <= 8'h18 && ra[1:0] == 2'h0;
  // Shadows follow completed writes only, so no view inside the block is needed.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
    lo_n <= transmit_pin ? 16'h0 : lo_n + 16'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fr <= USFB_RST_FRAME;
      dv <= USFB_RST_BAUD;
      db <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (wa == 8'h00) fr <= wd[7:0];
      if (wa == 8'h04) db <= wd[1];
      if (wa == 8'h08) dv[7:0] <= wd[7:0];
      if (wa == 8'h0C) dv[11:8] <= wd[3:0];
    end
  end
  property p_oe;
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> sync_clock_pin_oe == (fr[7:6] != 2'h1);
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock pin enable disagrees with mode");
  property p_frd;
    s_axi_rvalid && ra == 8'h00 |-> s_axi_rdata == {24'h0, fr};
  endproperty
  a_frd: assert property (p_frd)
    else $error("frame register read-back wrong");
  property p_hi;
    s_axi_rvalid && ra == 8'h0C |-> s_axi_rdata == {28'h0, dv[11:8]};
  endproperty
  a_hi: assert property (p_hi)
    else $error("divisor high byte read-back wrong");
  // Every low run ends on a bit boundary, so its length is whole bit times.
  property p_bit;
    $rose(transmit_pin) && fr[7:6] != 2'h1 |-> lo_n != 16'h0 && ({1'b0, lo_n} % bt) == 17'h0;
  endproperty
  a_bit: assert property (p_bit)
    else $error("serial bit time wrong");
  property p_wlat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wlat: assert property (p_wlat)
    else $error("write response late");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat)
    else $error("read data late");
  property p_rresp;
    s_axi_rvalid |-> rok ? s_axi_rresp == USFB_RESP_OKAY :
      {s_axi_rresp, s_axi_rdata} == {USFB_RESP_SLVERR, 32'h0};
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read response code wrong");
  property p_bresp;
    s_axi_bvalid |-> s_axi_bresp == (wok ? USFB_RESP_OKAY : USFB_RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response code wrong");
  property p_xck;
    $changed(sync_clock_pin_o) && dv != 12'h0 |=> $stable(sync_clock_pin_o);
  endproperty
  a_xck: assert property (p_xck)
    else $error("generated clock toggles too fast");
  c_sync: cover property (!sync_clock_pin_oe);
  c_dbl: cover property ($rose(transmit_pin) && db);
  c_bad: cover property (s_axi_rvalid && !rok);
endmodule
bind usfb_top usfb_sva chk_u (.*);

/* usfb_peer.sv */
`timescale 1ns/10ps
module usfb_peer (
  input wire logic tx_line,
  output logic rx_line,
  output logic clk_out
);
  // The clock stands still outside a synchronous transfer.
  initial begin
    rx_line = 1'b1;
    clk_out = 1'b0;
  end
  task automatic send(input logic [8:0] d, input int nb, input int pm, input logic bad,
                      input int bt);
    #13;
    rx_line = 1'b0;
    #(bt);
    for (int i = 0; i < nb; i++) begin
      rx_line = d[i];
      #(bt);
    end
    if (pm > 1) begin
      rx_line = ^(d & (9'h1FF >> (9 - nb))) ^ pm[0] ^ bad;
      #(bt);
    end
    rx_line = 1'b1;
    #(bt);
  endtask
  // Clock master for one synchronous frame; samples on the edge opposite the change edge.
  task automatic sync_grab(input int nb, input logic pol, output logic [8:0] d);
    int i;
    logic st;
    d = 9'h000;
    i = 0;
    st = 1'b0;
    repeat (16) begin
      #400 clk_out = !pol;
      #400 clk_out = pol;
      if (st && i < nb) begin
        d[i] = tx_line;
        i++;
      end
      st = st || !tx_line;
    end
  endtask
  task automatic grab(input int nb, input int pm, input int bt, output logic [8:0] d,
                      output logic p, output logic [1:0] s);
    int n;
    d = 9'h000;
    p = 1'b0;
    s = 2'bxx;
    for (n = 0; tx_line && n < 20000; n++) #10;
    if (n == 20000) return;
    #(bt / 2);
    for (int i = 0; i < nb; i++) begin
      #(bt);
      d[i] = tx_line;
    end
    if (pm > 1) begin
      #(bt);
      p = tx_line;
    end
    #(bt);
    s[0] = tx_line;
    #(bt);
    s[1] = tx_line;
  endtask
endmodule

/* usfb_bench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module usfb_bench import usfb_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic transmit_pin, receive_pin, sync_clock_pin_o, sync_clock_pin_oe, pclk;
  wire sync_clock_pin_i = sync_clock_pin_oe ? sync_clock_pin_o : pclk;
  int n_mismatch = 0, compares = 0;
  usfb_top dut_u (.*);
  usfb_peer peer_u (.tx_line(transmit_pin), .rx_line(receive_pin), .clk_out(pclk));
  always #25 aclk = ~aclk;
  task automatic wrap_up;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo;
    `CHK(1'b0, 1'b1)
    wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, output logic [33:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
    d = {s_axi_rresp, s_axi_rdata};
  endtask
  task automatic chk(input logic [7:0] a, input logic [33:0] e);
    logic [33:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic poll(input int b, input logic v);
    logic [33:0] d;
    int n;
    for (n = 0; n < 600; n++) begin
      rd(8'h10, d);
      if (d[b] === v) break;
    end
    if (n == 600) tmo();
  endtask
  task automatic t_regs;
    logic [31:0] v;
    chk(8'h00, 34'h06);
    chk(8'h04, 34'h0);
    chk(8'h0C, 34'h0);
    chk(8'h1C, {2'h2, 32'h0});
    wr(8'h1C, 32'h1, 2'h2);
    wr(8'h0C, 32'h5, 2'h0);
    chk(8'h0C, 34'h5);
    wr(8'h0C, 32'h0, 2'h0);
    for (int m = 0; m < 4; m++) begin
      v = {24'h0, m[1:0], 5'h03, 1'(m == 1)};
      wr(8'h00, v, 2'h0);
      chk(8'h00, {2'h0, v});
      `CHK(sync_clock_pin_oe, 1'(m != 1))
    end
  endtask
  task automatic t_tx;
    logic [6:0] cf [6] = '{7'h10, 7'h39, 7'h42, 7'h33, 7'h1F, 7'h64};
    logic [8:0] d, dd, msk;
    logic [1:0] s;
    logic p;
    int nb, bt;
    for (int i = 0; i < 6; i++) begin
      nb = cf[i][2:0] == 3'h7 ? 9 : cf[i][2] ? 8 : cf[i][2:0] + 5;
      bt = cf[i][6] ? 800 : 1600;
      msk = 9'h1FF >> (9 - nb);
      dd = i[0] ? 9'h15A : 9'h1A5;
      wr(8'h04, {27'h0, 2'h3, cf[i][2], cf[i][6], 1'b0}, 2'h0);
      wr(8'h00, {26'h0, cf[i][4:3], cf[i][5], cf[i][1:0], 1'b0}, 2'h0);
      wr(8'h08, 32'h1, 2'h0);
      // A second character is queued so a single stop bit shows the next start.
      fork
        peer_u.grab(nb, cf[i][4:3], bt, d, p, s);
        begin
          wr(8'h14, {23'h0, dd}, 2'h0);
          poll(4, 1'b1);
          wr(8'h14, 32'h0, 2'h0);
        end
      join
      `CHK(d, dd & msk)
      `CHK(p, cf[i][4] & (^(dd & msk) ^ cf[i][3]))
      `CHK(s, cf[i][5] ? 2'h3 : 2'h1)
      poll(0, 1'b0);
    end
  endtask
  task automatic t_rx;
    logic [33:0] d;
    wr(8'h04, 32'h18, 2'h0);
    wr(8'h00, 32'h2E, 2'h0);
    fork
      begin
        peer_u.send(9'h0C3, 8, 2, 1'b0, 1600);
        peer_u.send(9'h05A, 8, 2, 1'b1, 1600);
      end
      begin
        poll(1, 1'b1);
        rd(8'h10, d);
        `CHK(d[3:2], 2'h0)
        chk(8'h18, 34'h0C3);
        poll(1, 1'b1);
        rd(8'h10, d);
        `CHK(d[2], 1'b1)
        chk(8'h18, 34'h05A);
      end
    join
  endtask
  task automatic t_sync;
    logic [8:0] d;
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, {24'h0, 2'h1, 5'h03, 1'(k)}, 2'h0);
      wr(8'h14, 32'h0B4 >> k, 2'h0);
      peer_u.sync_grab(8, 1'(k), d);
      `CHK(d, 9'h0B4 >> k)
    end
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_sync();
    wrap_up();
  end
endmodule
